// *** bst_ctl_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module bst_ctl_model (
	output var  logic tck,
	output var  logic tms,
	output var  logic tdi,
	input  wire logic tdo_w,
	input  wire logic tdo_oe_n
);
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one tck cycle; clock rests low between calls
	task automatic step(input logic m, input logic d, output logic q, output logic z);
		tms = m;
		tdi = d;
		#15;
		q = tdo_w;
		z = tdo_oe_n;
		tck = 1'b1;
		#15;
		tck = 1'b0;
	endtask
endmodule
`default_nettype wire

// *** bst_pkg.sv ***
package bst_pkg;

	// tap controller states
	typedef enum logic [3:0] {
		bst_s_reset,
		bst_s_idle,
		bst_s_sel_dr,
		bst_s_cap_dr,
		bst_s_shift_dr,
		bst_s_exit1_dr,
		bst_s_pause_dr,
		bst_s_exit2_dr,
		bst_s_upd_dr,
		bst_s_sel_ir,
		bst_s_cap_ir,
		bst_s_shift_ir,
		bst_s_exit1_ir,
		bst_s_pause_ir,
		bst_s_exit2_ir,
		bst_s_upd_ir
	} bst_tap_state_t;

	localparam int          BST_IR_W       = 8;
	localparam int          BST_DR_W       = 8;
	localparam int          BST_SYNC_DEPTH = 2;
	localparam logic [7:0]  BST_IR_CAPTURE = 8'h81;
	localparam logic [7:0]  BST_IR_BYPASS  = 8'hFF;
	localparam logic [7:0]  BST_IR_RESET   = 8'hFF;
	localparam logic        BST_BYP_CAPTURE = 1'h0;
	localparam logic [7:0]  BST_DR_RESET   = 8'h00;
	localparam logic [7:0]  BST_OUT_RESET  = 8'h00;

endpackage

// *** bst_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module bst_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	logic [W-1:0] meta_r;

	// first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					meta_r[i] <= 1'h0;
					q[i]      <= 1'h0;
				end
				else
				begin
					meta_r[i] <= d[i];
					q[i]      <= meta_r[i];
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// *** bst_tap.sv ***
// Contract
// - all test state and registers change only with the test clock
// - test input, mode-select and normal inputs sampled on rising test clock
// - test output and normal outputs change only on falling test clock
// - 8-bit instruction register captures 10000001 leaving Capture-IR
// - shift states take test input and present selected register on output
// - selected shift register advances one bit per rising edge in shift
// - output driver enabled on falling edge after entering a shift state
// - output driver released on falling edge in Exit1-IR or Exit1-DR
// - last instruction bit shifts on the edge from Shift-IR to Exit1-IR
// - instruction 11111111 selects the one-stage bypass register
// - shifted instruction becomes active on falling edge in Update-IR only
// - bypass register loads zero leaving Capture-DR
// - selected data register copied to output latches on falling edge in Update-DR
`timescale 1ns/10ps
`default_nettype none

module bst_tap (
	input  wire logic                         clock,
	input  wire logic                         rst,
	input  wire logic                         tck,
	input  wire logic                         tms,
	input  wire logic                         tdi,
	output var  logic                         tdo_o,
	output var  logic                         tdo_oe_n,
	input  wire logic [bst_pkg::BST_DR_W-1:0] func_in,
	output var  logic [bst_pkg::BST_DR_W-1:0] func_out,
	output var  logic [bst_pkg::BST_DR_W-1:0] upd_data,
	output var  logic                         upd_strobe,
	output var  logic                         test_mode
);

	bst_pkg::bst_tap_state_t state_r;
	bst_pkg::bst_tap_state_t state_nxt;

	logic                         rst_tck;
	logic [bst_pkg::BST_IR_W-1:0] ir_shift_r;
	logic [bst_pkg::BST_IR_W-1:0] ir_active_r;
	logic                         bypass_r;
	logic [bst_pkg::BST_DR_W-1:0] dr_shift_r;
	logic [bst_pkg::BST_DR_W-1:0] func_in_s;
	logic [bst_pkg::BST_DR_W-1:0] xfer_word_r;
	logic                         xfer_req_r;
	logic                         xfer_ack_tgl;
	logic                         xfer_ack_s;
	logic                         test_mode_tck_r;

	function automatic logic is_shift(input bst_pkg::bst_tap_state_t s);
		is_shift = (s == bst_pkg::bst_s_shift_ir) || (s == bst_pkg::bst_s_shift_dr);
	endfunction

	function automatic logic sel_bypass(input logic [bst_pkg::BST_IR_W-1:0] ir);
		sel_bypass = (ir == bst_pkg::BST_IR_BYPASS);
	endfunction

	// system reset reaches the test domain through two tck flops;
	// the tck may be stopped, so reset only lands once tck runs
	bst_sync #(.W(1)) u_rst_sync (
		.clk (tck),
		.rst (1'h0),
		.d   (rst),
		.q   (rst_tck)
	);

	// normal-function pins sampled on the rising test clock
	bst_sync #(.W(bst_pkg::BST_DR_W)) u_in_sync (
		.clk (tck),
		.rst (rst_tck),
		.d   (func_in),
		.q   (func_in_s)
	);

	bst_sync #(.W(1)) u_ack_sync (
		.clk (tck),
		.rst (rst_tck),
		.d   (xfer_ack_tgl),
		.q   (xfer_ack_s)
	);

	// next state from the mode-select level
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			bst_pkg::bst_s_reset:
			begin
				// low mode-select leaves reset for idle
				state_nxt = tms ? bst_pkg::bst_s_reset : bst_pkg::bst_s_idle;
			end
			bst_pkg::bst_s_idle:
			begin
				state_nxt = tms ? bst_pkg::bst_s_sel_dr : bst_pkg::bst_s_idle;
			end
			bst_pkg::bst_s_sel_dr:
			begin
				state_nxt = tms ? bst_pkg::bst_s_sel_ir : bst_pkg::bst_s_cap_dr;
			end
			bst_pkg::bst_s_cap_dr:
			begin
				state_nxt = tms ? bst_pkg::bst_s_exit1_dr : bst_pkg::bst_s_shift_dr;
			end
			bst_pkg::bst_s_shift_dr:
			begin
				state_nxt = tms ? bst_pkg::bst_s_exit1_dr : bst_pkg::bst_s_shift_dr;
			end
			bst_pkg::bst_s_exit1_dr:
			begin
				state_nxt = tms ? bst_pkg::bst_s_upd_dr : bst_pkg::bst_s_pause_dr;
			end
			bst_pkg::bst_s_pause_dr:
			begin
				state_nxt = tms ? bst_pkg::bst_s_exit2_dr : bst_pkg::bst_s_pause_dr;
			end
			bst_pkg::bst_s_exit2_dr:
			begin
				state_nxt = tms ? bst_pkg::bst_s_upd_dr : bst_pkg::bst_s_shift_dr;
			end
			bst_pkg::bst_s_upd_dr:
			begin
				state_nxt = tms ? bst_pkg::bst_s_sel_dr : bst_pkg::bst_s_idle;
			end
			bst_pkg::bst_s_sel_ir:
			begin
				state_nxt = tms ? bst_pkg::bst_s_reset : bst_pkg::bst_s_cap_ir;
			end
			bst_pkg::bst_s_cap_ir:
			begin
				state_nxt = tms ? bst_pkg::bst_s_exit1_ir : bst_pkg::bst_s_shift_ir;
			end
			bst_pkg::bst_s_shift_ir:
			begin
				state_nxt = tms ? bst_pkg::bst_s_exit1_ir : bst_pkg::bst_s_shift_ir;
			end
			bst_pkg::bst_s_exit1_ir:
			begin
				state_nxt = tms ? bst_pkg::bst_s_upd_ir : bst_pkg::bst_s_pause_ir;
			end
			bst_pkg::bst_s_pause_ir:
			begin
				state_nxt = tms ? bst_pkg::bst_s_exit2_ir : bst_pkg::bst_s_pause_ir;
			end
			bst_pkg::bst_s_exit2_ir:
			begin
				state_nxt = tms ? bst_pkg::bst_s_upd_ir : bst_pkg::bst_s_shift_ir;
			end
			bst_pkg::bst_s_upd_ir:
			begin
				state_nxt = tms ? bst_pkg::bst_s_sel_dr : bst_pkg::bst_s_idle;
			end
			default:
			begin
				state_nxt = bst_pkg::bst_s_reset;
			end
		endcase
	end

	// state advances on the rising edge after the falling-edge tms change
	always_ff @(posedge tck)
	begin
		if (rst_tck)
		begin
			state_r <= bst_pkg::bst_s_reset;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// instruction shift register, lsb out first
	always_ff @(posedge tck)
	begin
		if (rst_tck)
		begin
			ir_shift_r <= bst_pkg::BST_IR_CAPTURE;
		end
		else if (state_r == bst_pkg::bst_s_cap_ir)
		begin
			ir_shift_r <= bst_pkg::BST_IR_CAPTURE;
		end
		else if (state_r == bst_pkg::bst_s_shift_ir)
		begin
			// includes the edge into Exit1-IR
			ir_shift_r <= {tdi, ir_shift_r[bst_pkg::BST_IR_W-1:1]};
		end
	end

	// active instruction only moves in Update-IR or the reset state, on the falling edge
	always_ff @(negedge tck)
	begin
		if (rst_tck)
		begin
			ir_active_r <= bst_pkg::BST_IR_RESET;
		end
		else if (state_r == bst_pkg::bst_s_reset)
		begin
			ir_active_r <= bst_pkg::BST_IR_RESET;
		end
		else if (state_r == bst_pkg::bst_s_upd_ir)
		begin
			ir_active_r <= ir_shift_r;
		end
	end

	// single-stage bypass path
	always_ff @(posedge tck)
	begin
		if (rst_tck)
		begin
			bypass_r <= bst_pkg::BST_BYP_CAPTURE;
		end
		else if (sel_bypass(ir_active_r))
		begin
			if (state_r == bst_pkg::bst_s_cap_dr)
			begin
				bypass_r <= bst_pkg::BST_BYP_CAPTURE;
			end
			else if (state_r == bst_pkg::bst_s_shift_dr)
			begin
				bypass_r <= tdi;
			end
		end
	end

	// any other instruction scans the sampled normal inputs
	always_ff @(posedge tck)
	begin
		if (rst_tck)
		begin
			dr_shift_r <= bst_pkg::BST_DR_RESET;
		end
		else if (!sel_bypass(ir_active_r))
		begin
			if (state_r == bst_pkg::bst_s_cap_dr)
			begin
				dr_shift_r <= func_in_s;
			end
			else if (state_r == bst_pkg::bst_s_shift_dr)
			begin
				dr_shift_r <= {tdi, dr_shift_r[bst_pkg::BST_DR_W-1:1]};
			end
		end
	end

	// test output data and driver on the falling edge only
	always_ff @(negedge tck)
	begin
		if (rst_tck)
		begin
			tdo_o    <= 1'h0;
			tdo_oe_n <= 1'h1;
		end
		else
		begin
			// released in exit1 and every non-shift state
			if (is_shift(state_r))
			begin
				tdo_oe_n <= 1'h0;
			end
			else
			begin
				tdo_oe_n <= 1'h1;
			end
			if (state_r == bst_pkg::bst_s_shift_ir)
			begin
				tdo_o <= ir_shift_r[0];
			end
			else if (state_r == bst_pkg::bst_s_shift_dr)
			begin
				tdo_o <= sel_bypass(ir_active_r) ? bypass_r : dr_shift_r[0];
			end
		end
	end

	// output latches follow the scanned word in Update-DR
	always_ff @(negedge tck)
	begin
		if (rst_tck)
		begin
			func_out <= bst_pkg::BST_OUT_RESET;
		end
		else if (state_r == bst_pkg::bst_s_upd_dr && !sel_bypass(ir_active_r))
		begin
			func_out <= dr_shift_r;
		end
	end

	// test mode whenever a non-bypass instruction is active
	always_ff @(negedge tck)
	begin
		if (rst_tck)
		begin
			test_mode_tck_r <= 1'h0;
		end
		else
		begin
			test_mode_tck_r <= !sel_bypass(ir_active_r);
		end
	end

	// word toward the system clock; an update is skipped for the system side
	// while the previous word is unacknowledged, the pins still follow
	always_ff @(negedge tck)
	begin
		if (rst_tck)
		begin
			xfer_word_r <= bst_pkg::BST_OUT_RESET;
			xfer_req_r  <= 1'h0;
		end
		else if (state_r == bst_pkg::bst_s_upd_dr && !sel_bypass(ir_active_r)
			&& xfer_ack_s == xfer_req_r)
		begin
			xfer_word_r <= dr_shift_r;
			xfer_req_r  <= !xfer_req_r;
		end
	end

	bst_word_rx u_rx (
		.clock     (clock),
		.rst       (rst),
		.req_tgl   (xfer_req_r),
		.word      (xfer_word_r),
		.word_r    (upd_data),
		.strobe_r  (upd_strobe),
		.ack_tgl_r (xfer_ack_tgl)
	);

	bst_sync #(.W(1)) u_mode_sync (
		.clk (clock),
		.rst (rst),
		.d   (test_mode_tck_r),
		.q   (test_mode)
	);

endmodule
`default_nettype wire

// *** bst_tap_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module bst_tap_chk (
	input  wire logic                         clock,
	input  wire logic                         rst,
	input  wire logic                         tck,
	input  wire logic                         tms,
	input  wire logic                         tdi,
	input  wire logic                         tdo_o,
	input  wire logic                         tdo_oe_n,
	input  wire logic [bst_pkg::BST_DR_W-1:0] func_in,
	input  wire logic [bst_pkg::BST_DR_W-1:0] func_out,
	input  wire logic [bst_pkg::BST_DR_W-1:0] upd_data,
	input  wire logic                         upd_strobe,
	input  wire logic                         test_mode
);
	// pin values seen just before each rising tck
	logic [bst_pkg::BST_DR_W+1:0] hold_r;
	always_ff @(posedge tck)
	begin
		hold_r <= {tdo_o, tdo_oe_n, func_out};
	end
	sequence s_five_ones;
		tms [*5];
	endsequence
	chk_strobe_one_pulse: assert property (
		@(posedge clock) disable iff (rst) upd_strobe |=> !upd_strobe [*3])
		else $error("update strobe not a single pulse");
	chk_word_with_strobe: assert property (
		@(posedge clock) disable iff (rst) $changed(upd_data) |-> upd_strobe)
		else $error("update word changed without strobe");
	chk_word_matches_pins: assert property (
		@(posedge clock) disable iff (rst) upd_strobe |-> upd_data == func_out)
		else $error("update word differs from output latches");
	chk_no_rise_change: assert property (
		@(negedge tck) disable iff (rst) {tdo_o, tdo_oe_n, func_out} == hold_r)
		else $error("output changed on rising test clock");
	chk_drive_after_shift: assert property (
		@(negedge tck) disable iff (rst) $fell(tdo_oe_n) |-> !$past(tms))
		else $error("driver enabled outside shift entry");
	chk_release_exit1: assert property (
		@(negedge tck) disable iff (rst) $rose(tdo_oe_n) |-> $past(tms))
		else $error("driver released without exit");
	chk_shift_holds: assert property (
		@(negedge tck) disable iff (rst) !tdo_oe_n && !tms |=> !tdo_oe_n)
		else $error("driver dropped while still shifting");
	chk_shift_leaves: assert property (
		@(negedge tck) disable iff (rst) !tdo_oe_n && tms |=> tdo_oe_n)
		else $error("driver kept on in exit state");
	chk_five_ones_reset: assert property (
		@(negedge tck) disable iff (rst) s_five_ones |=> tdo_oe_n)
		else $error("five high mode-select edges did not reset");
endmodule
bind bst_tap bst_tap_chk bst_tap_chk_inst (
	.clock      (clock),
	.rst        (rst),
	.tck        (tck),
	.tms        (tms),
	.tdi        (tdi),
	.tdo_o      (tdo_o),
	.tdo_oe_n   (tdo_oe_n),
	.func_in    (func_in),
	.func_out   (func_out),
	.upd_data   (upd_data),
	.upd_strobe (upd_strobe),
	.test_mode  (test_mode)
);
`default_nettype wire

// *** bst_word_rx.sv ***
`timescale 1ns/10ps
`default_nettype none

module bst_word_rx (
	input  wire logic                       clock,
	input  wire logic                       rst,
	input  wire logic                       req_tgl,
	input  wire logic [bst_pkg::BST_DR_W-1:0] word,
	output var  logic [bst_pkg::BST_DR_W-1:0] word_r,
	output var  logic                       strobe_r,
	output var  logic                       ack_tgl_r
);

	logic req_s;

	bst_sync #(.W(1)) u_req_sync (
		.clk (clock),
		.rst (rst),
		.d   (req_tgl),
		.q   (req_s)
	);

	// word is held still by the sender until the ack toggle returns
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			word_r    <= bst_pkg::BST_OUT_RESET;
			strobe_r  <= 1'h0;
			ack_tgl_r <= 1'h0;
		end
		else
		begin
			strobe_r <= 1'h0;
			if (req_s != ack_tgl_r)
			begin
				word_r    <= word;
				strobe_r  <= 1'h1;
				ack_tgl_r <= req_s;
			end
		end
	end

endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) \
	begin \
		cmp_count++; \
		if ((a) !== (b)) \
		begin \
			failures++; \
			$display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (b)); \
		end \
	end
module tb_top;
	logic       clock;
	logic       rst;
	logic       tck;
	logic       tms;
	logic       tdi;
	logic       tdo_o;
	logic       tdo_oe_n;
	wire  logic tdo_w;
	logic [7:0] func_in;
	logic [7:0] func_out;
	logic [7:0] upd_data;
	logic       upd_strobe;
	logic       test_mode;
	logic       q;
	logic       z;
	logic [7:0] d;
	int         failures;
	int         cmp_count;
	assign tdo_w = tdo_oe_n ? 1'bz : tdo_o;
	bst_tap bst_tap_inst (
		.clock      (clock),
		.rst        (rst),
		.tck        (tck),
		.tms        (tms),
		.tdi        (tdi),
		.tdo_o      (tdo_o),
		.tdo_oe_n   (tdo_oe_n),
		.func_in    (func_in),
		.func_out   (func_out),
		.upd_data   (upd_data),
		.upd_strobe (upd_strobe),
		.test_mode  (test_mode)
	);
	bst_ctl_model bst_ctl_model_inst (
		.tck      (tck),
		.tms      (tms),
		.tdi      (tdi),
		.tdo_w    (tdo_w),
		.tdo_oe_n (tdo_oe_n)
	);
	always #50 clock = ~clock;
	task automatic close_out();
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic st(input logic m, input logic dv);
		bst_ctl_model_inst.step(m, dv, q, z);
	endtask
	// idle -> shift -> n bits -> exit1 -> update -> idle
	task automatic scan(input logic ir, input int n, input logic [7:0] din);
		d = 8'h00;
		st(1'b1, 1'b0);
		if (ir)
			st(1'b1, 1'b0);
		st(1'b0, 1'b0);
		st(1'b0, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			st(i == n - 1, din[i]);
			`CHK(z, 1'b0);
			d[i] = q;
		end
		st(1'b1, 1'b0);
		`CHK(z, 1'b1);
		st(1'b0, 1'b0);
	endtask
	// system side sees the instruction only after sync
	task automatic wait_mode(input logic v);
		int i;
		for (i = 0; i < 20 && test_mode !== v; i++)
			@(negedge clock);
		`CHK(test_mode, v);
		if (i == 20)
			close_out();
	endtask
	task automatic t_reset();
		`CHK({tdo_oe_n, test_mode, upd_data, func_out}, 18'h20000);
		st(1'b0, 1'b0);
	endtask
	task automatic t_ir_capture();
		scan(1'b1, 8, 8'h5A);
		`CHK(d, 8'h81);
		wait_mode(1'b1);
	endtask
	task automatic t_dr_data();
		int i;
		scan(1'b0, 8, 8'h3C);
		`CHK(d, 8'hC3);
		`CHK(func_out, 8'h3C);
		for (i = 0; i < 20 && upd_strobe !== 1'b1; i++)
			@(negedge clock);
		`CHK(upd_data, 8'h3C);
		if (i == 20)
			close_out();
	endtask
	task automatic t_bypass();
		scan(1'b1, 8, 8'hFF);
		`CHK(d, 8'h81);
		wait_mode(1'b0);
		scan(1'b0, 3, 8'h05);
		`CHK(d[2:0], 3'b010);
		`CHK(func_out, 8'h3C);
		// last bit left a one in bypass, so capture must clear it
		scan(1'b0, 1, 8'h00);
		`CHK(d[0], 1'b0);
	endtask
	task automatic t_five_ones();
		scan(1'b1, 8, 8'h00);
		wait_mode(1'b1);
		repeat (5) st(1'b1, 1'b0);
		wait_mode(1'b0);
	endtask
	initial
	begin
		clock = 1'b0;
		rst = 1'b1;
		func_in = 8'hC3;
		failures = 0;
		cmp_count = 0;
		// test side resets through tck, so it must run meanwhile
		repeat (12) st(1'b1, 1'b0);
		@(negedge clock);
		rst = 1'b0;
		repeat (4) st(1'b1, 1'b0);
		t_reset();
		t_ir_capture();
		t_dr_data();
		t_bypass();
		t_five_ones();
		close_out();
	end
endmodule
`default_nettype wire
